// >>> rtl/ascii_command_parser.sv
// Operation
// - Read frame: start mark, address, upper letters, value (peek only), CR
// - Write frame: lower letters, value, then CR
// - Value is everything between letters and CR
// - Letter case selects read or write
// - Station read replies seven characters
// - Station write 01..99 adopted, no reply
// - Line speed write accepts listed rates only
// - Line speed read replies eleven characters
// - Dump: 160 bytes, 16 per 65-char line
// - Peek replies three digits plus CR LF
// - Peek location becomes current pointer
// - Poke stores 000..255 at pointer
// - Poke echoes three digits plus CR LF
// - Poke pulses coefficient reload flag
// - Other writes silent unless error
// - Range read replies thirteen characters
// - Version read replies seven characters
// - Serial tag read replies eleven characters
// - Pressure read replies thirteen characters
// - Pressure kind read replies six characters
// - Raw sample read replies 54 characters
// - Never transmit without a request
// - Double asterisk address matches this unit
// - Bad write syntax returns error code
module ascii_command_parser import parser_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [63:0] pressure_text,
  input wire logic [63:0] range_text,
  input wire logic [47:0] serial_text,
  input wire logic [7:0] kind_char,
  input wire logic [415:0] raw_text,
  output logic [2:0] line_speed_sel,
  output logic coeff_reload
);
  localparam int MSG_BITS = MSG_CHARS * 8;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_t state_reg, state_next;
  reply_t reply_reg, reply_next;
  logic [15:0] addr_reg, addr_next, name_reg, name_next;
  logic [15:0] station_reg, station_next;
  logic [47:0] val_reg, val_next;
  logic [2:0] cnt_reg, cnt_next, speed_reg, speed_next;
  logic ovf_reg, ovf_next, reload_reg, reload_next;
  logic [6:0] idx_reg, idx_next, len_reg, len_next;
  logic [3:0] line_reg, line_next;
  logic [7:0] ptr_reg, ptr_next, tx_data_reg, tx_data_next;
  logic tx_valid_reg, tx_valid_next, rx_ready_reg, rx_ready_next;
  logic [7:0] nvm [NVM_DEPTH];
  logic mem_we;

  function automatic logic is_dig(input logic [7:0] c);
    return c >= 8'h30 && c <= 8'h39;
  endfunction : is_dig

  function automatic logic [23:0] dec3(input logic [7:0] v);
    logic [7:0] h, t, o;
    h = v / 8'd100;
    t = (v % 8'd100) / 8'd10;
    o = v % 8'd10;
    return {CH_ZERO + h, CH_ZERO + t, CH_ZERO + o};
  endfunction : dec3

  // ----------------------------------------------------------------
  // Frame classification
  // ----------------------------------------------------------------
  logic take, frame_end, addr_ok, rd, wr, num_ok, go;
  logic [15:0] upname;
  logic [9:0] val_num;
  logic [RATE_COUNT-1:0] rate_hit;
  logic [2:0] rate_idx;
  logic station_ok, speed_ok, poke_ok, peek_ok, wr_err;
  reply_t rd_kind;
  logic [6:0] rd_len;
  logic rd_known;

  // Case of both letters decides direction; mixed case is neither
  assign take = rx_valid && rx_ready_reg;
  assign frame_end = take && state_reg == st_value && rx_data == CH_CR;
  assign addr_ok = addr_reg == station_reg
    || addr_reg == WILDCARD;
  assign upname = name_reg & ~CASE_BITS;
  assign rd = upname == name_reg && upname[15:8] >= 8'h41
    && upname[15:8] <= 8'h5A && upname[7:0] >= 8'h41
    && upname[7:0] <= 8'h5A;
  assign wr = upname != name_reg && (name_reg & CASE_BITS) == CASE_BITS
    && upname[15:8] >= 8'h41 && upname[15:8] <= 8'h5A
    && upname[7:0] >= 8'h41 && upname[7:0] <= 8'h5A;
  assign go = frame_end && addr_ok;

  // Three-digit values, as used by the peek and poke commands
  assign val_num = 10'(val_reg[47:40] - CH_ZERO) * 10'd100
    + 10'(val_reg[39:32] - CH_ZERO) * 10'd10
    + 10'(val_reg[31:24] - CH_ZERO);
  assign num_ok = !ovf_reg && cnt_reg == 3'd3 && is_dig(val_reg[47:40])
    && is_dig(val_reg[39:32]) && is_dig(val_reg[31:24])
    && val_num <= BYTE_MAX;

  // Each listed rate is compared against the padded value text
  genvar g;
  generate
    for (g = 0; g < RATE_COUNT; g++) begin : g_rate
      assign rate_hit[g] = !ovf_reg && val_reg == RATE_TEXT[g];
    end
  endgenerate

  always_comb begin
    rate_idx = RATE_RESET;
    for (int i = 0; i < RATE_COUNT; i++) begin
      if (rate_hit[i]) begin
        rate_idx = 3'(i);
      end
    end
  end

  assign station_ok = go && wr && upname == LETTERS_STATION
    && !ovf_reg && cnt_reg == 3'd2 && is_dig(val_reg[47:40])
    && is_dig(val_reg[39:32])
    && val_reg[47:32] != STATION_NONE;
  assign speed_ok = go && wr && upname == LETTERS_LINE_SPEED
    && |rate_hit;
  assign poke_ok = go && wr && upname == LETTERS_NVM_POKE && num_ok;
  assign peek_ok = go && rd && upname == LETTERS_NVM_PEEK && num_ok;
  assign wr_err = go && wr && !station_ok && !speed_ok
    && !poke_ok;

  // Read decode; a read with a stray value is dropped
  always_comb begin
    rd_kind = station_cmd;
    rd_len = LEN_STATION;
    rd_known = cnt_reg == 3'd0 && !ovf_reg;
    case (upname)
      LETTERS_STATION: begin
      end
      LETTERS_LINE_SPEED: begin
        rd_kind = line_speed_cmd;
        rd_len = LEN_SPEED;
      end
      LETTERS_NVM_DUMP: begin
        rd_kind = nvm_dump_cmd;
        rd_len = LEN_DUMP_LINE;
      end
      LETTERS_NVM_PEEK: begin
        rd_kind = nvm_peek_cmd;
        rd_len = LEN_NVM;
        rd_known = num_ok;
      end
      LETTERS_RANGE: begin
        rd_kind = range_limit_cmd;
        rd_len = LEN_RANGE;
      end
      LETTERS_VERSION: begin
        rd_kind = code_version_cmd;
        rd_len = LEN_VERSION;
      end
      LETTERS_TAG: begin
        rd_kind = serial_tag_cmd;
        rd_len = LEN_TAG;
      end
      LETTERS_PRESSURE: begin
        rd_kind = pressure_query_cmd;
        rd_len = LEN_PRESSURE;
      end
      LETTERS_KIND: begin
        rd_kind = sensing_kind_cmd;
        rd_len = LEN_KIND;
      end
      LETTERS_RAW: begin
        rd_kind = raw_sample_cmd;
        rd_len = LEN_RAW;
      end
      default: begin
        rd_known = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Reply text
  // ----------------------------------------------------------------
  logic [MSG_BITS-1:0] msg, msg_sh;
  logic [23:0] dump_dig;
  logic [7:0] out_char;

  // Live inputs are read while sending, so a value may tear mid-reply
  always_comb begin
    msg = '0;
    case (reply_reg)
      station_cmd: msg[MSG_BITS-1 -: 56] =
        {LETTERS_STATION, CH_EQ, station_reg, CH_CR, CH_LF};
      line_speed_cmd: msg[MSG_BITS-1 -: 88] = {LETTERS_LINE_SPEED,
        CH_EQ, RATE_TEXT[speed_reg], CH_CR, CH_LF};
      nvm_peek_cmd: msg[MSG_BITS-1 -: 40] =
        {dec3(nvm[ptr_reg]), CH_CR, CH_LF};
      nvm_poke_cmd: msg[MSG_BITS-1 -: 40] =
        {val_reg[47:24], CH_CR, CH_LF};
      range_limit_cmd: msg[MSG_BITS-1 -: 104] =
        {LETTERS_RANGE, CH_EQ, range_text, CH_CR, CH_LF};
      code_version_cmd: msg[MSG_BITS-1 -: 56] =
        {VERSION_TEXT, CH_CR, CH_LF};
      serial_tag_cmd: msg[MSG_BITS-1 -: 88] =
        {LETTERS_TAG, CH_EQ, serial_text, CH_CR, CH_LF};
      pressure_query_cmd: msg[MSG_BITS-1 -: 104] = {LETTERS_PRESSURE,
        CH_EQ, pressure_text, CH_CR, CH_LF};
      sensing_kind_cmd: msg[MSG_BITS-1 -: 48] =
        {LETTERS_KIND, CH_EQ, kind_char, CH_CR, CH_LF};
      raw_sample_cmd: msg = {raw_text, CH_CR, CH_LF};
      error_reply: msg[MSG_BITS-1 -: 56] =
        {ERROR_TEXT, CH_CR, CH_LF};
      default: msg = '0;
    endcase
  end

  // Dump line: 16 three-digit values, space separated, then CR LF
  assign dump_dig = dec3(nvm[{line_reg, idx_reg[5:2]}]);
  assign msg_sh = msg << {idx_reg, 3'b000};

  always_comb begin
    out_char = msg_sh[MSG_BITS-1 -: 8];
    if (reply_reg == nvm_dump_cmd) begin
      if (idx_reg == DUMP_CR_POS) begin
        out_char = CH_CR;
      end else if (idx_reg > DUMP_CR_POS) begin
        out_char = CH_LF;
      end else begin
        case (idx_reg[1:0])
          2'd0: out_char = dump_dig[23:16];
          2'd1: out_char = dump_dig[15:8];
          2'd2: out_char = dump_dig[7:0];
          default: out_char = CH_SPACE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencer and transmitter
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    reply_next = reply_reg;
    addr_next = addr_reg;
    name_next = name_reg;
    station_next = station_reg;
    val_next = val_reg;
    cnt_next = cnt_reg;
    speed_next = speed_reg;
    ovf_next = ovf_reg;
    reload_next = 1'b0;
    idx_next = idx_reg;
    len_next = len_reg;
    line_next = line_reg;
    ptr_next = ptr_reg;
    tx_data_next = tx_data_reg;
    tx_valid_next = tx_valid_reg;
    mem_we = 1'b0;
    case (state_reg)
      st_idle: if (take && rx_data == CH_START) state_next = st_addr_hi;
      st_addr_hi: if (take) begin
        addr_next[15:8] = rx_data;
        state_next = st_addr_lo;
      end
      st_addr_lo: if (take) begin
        addr_next[7:0] = rx_data;
        state_next = st_cmd_hi;
      end
      st_cmd_hi: if (take) begin
        name_next[15:8] = rx_data;
        state_next = st_cmd_lo;
      end
      st_cmd_lo: if (take) begin
        name_next[7:0] = rx_data;
        val_next = {6{CH_SPACE}};
        cnt_next = 3'd0;
        ovf_next = 1'b0;
        state_next = st_value;
      end
      st_value: if (frame_end) begin
        state_next = st_idle;
        idx_next = 7'd0;
        line_next = 4'd0;
        if (station_ok) begin
          station_next = val_reg[47:32];
        end else if (speed_ok) begin
          speed_next = rate_idx;
        end else if (poke_ok) begin
          mem_we = 1'b1;
          reload_next = 1'b1;
          reply_next = nvm_poke_cmd;
          len_next = LEN_NVM;
          state_next = st_send;
        end else if (wr_err) begin
          reply_next = error_reply;
          len_next = LEN_ERROR;
          state_next = st_send;
        end else if (go && rd && rd_known) begin
          if (peek_ok) ptr_next = val_num[7:0];
          reply_next = rd_kind;
          len_next = rd_len;
          state_next = st_send;
        end
      end else if (take) begin
        // Long values are flagged, never wrapped into the buffer
        if (cnt_reg == VALUE_CHARS) begin
          ovf_next = 1'b1;
        end else begin
          val_next[47 - 8 * cnt_reg -: 8] = rx_data;
          cnt_next = cnt_reg + 3'd1;
        end
      end
      st_send: if (!tx_valid_reg || tx_ready) begin
        if (idx_reg == len_reg) begin
          tx_valid_next = 1'b0;
          if (reply_reg == nvm_dump_cmd && line_reg != DUMP_LAST_LINE) begin
            line_next = line_reg + 4'd1;
            idx_next = 7'd0;
          end else begin
            state_next = st_idle;
          end
        end else begin
          tx_data_next = out_char;
          tx_valid_next = 1'b1;
          idx_next = idx_reg + 7'd1;
        end
      end
      default: state_next = st_idle;
    endcase
    // A start mark always resynchronises a frame in progress
    if (take && rx_data == CH_START && state_reg != st_idle) begin
      state_next = st_addr_hi;
    end
  end

  assign rx_ready_next = state_next != st_send;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= st_idle;
      reply_reg <= station_cmd;
      addr_reg <= '0;
      name_reg <= '0;
      station_reg <= STATION_RESET;
      val_reg <= '0;
      cnt_reg <= '0;
      speed_reg <= RATE_RESET;
      ovf_reg <= 1'b0;
      reload_reg <= 1'b0;
      idx_reg <= '0;
      len_reg <= '0;
      line_reg <= '0;
      ptr_reg <= '0;
      tx_data_reg <= '0;
      tx_valid_reg <= 1'b0;
      rx_ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      reply_reg <= reply_next;
      addr_reg <= addr_next;
      name_reg <= name_next;
      station_reg <= station_next;
      val_reg <= val_next;
      cnt_reg <= cnt_next;
      speed_reg <= speed_next;
      ovf_reg <= ovf_next;
      reload_reg <= reload_next;
      idx_reg <= idx_next;
      len_reg <= len_next;
      line_reg <= line_next;
      ptr_reg <= ptr_next;
      tx_data_reg <= tx_data_next;
      tx_valid_reg <= tx_valid_next;
      rx_ready_reg <= rx_ready_next;
    end
  end

  // Nonvolatile image; cleared at reset so a dump is always defined
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < NVM_DEPTH; i++) nvm[i] <= 8'h00;
    end else if (mem_we) begin
      nvm[ptr_reg] <= val_num[7:0];
    end
  end

  assign rx_ready = rx_ready_reg;
  assign tx_data = tx_data_reg;
  assign tx_valid = tx_valid_reg;
  assign line_speed_sel = speed_reg;
  assign coeff_reload = reload_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Reload pulse seen while no further memory write is in flight
  logic coeff_reload_reg_chk;
  assign coeff_reload_reg_chk = reload_reg && mem_we == 1'b0;

  sequence s_reply_start(reply_t k, logic [6:0] n);
    state_reg == st_send && reply_reg == k && len_reg == n
      && idx_reg == 7'd0;
  endsequence

  a_tx_only_replies: assert property (
    $rose(tx_valid_reg) |-> $past(state_reg) == st_send)
    else $error("transmit without a pending reply");
  a_poke_echo: assert property (
    poke_ok |=> s_reply_start(nvm_poke_cmd, LEN_NVM) ##1 tx_valid_reg
      && tx_data_reg == $past(val_reg[47:40], 2))
    else $error("poke echo not started");
  a_poke_reload: assert property (
    poke_ok |=> coeff_reload_reg_chk ##1 !reload_reg)
    else $error("reload flag not a single pulse");
  a_peek_pointer: assert property (
    peek_ok |=> ptr_reg == $past(val_num[7:0])
      and s_reply_start(nvm_peek_cmd, LEN_NVM))
    else $error("peek did not latch pointer");
  a_station_adopt: assert property (
    station_ok |=> station_reg == $past(val_reg[47:32])
      && state_reg == st_idle [*2])
    else $error("station write not adopted silently");
  a_speed_listed: assert property (
    speed_reg != $past(speed_reg) |-> $past(speed_ok))
    else $error("line speed changed without valid rate");
  a_error_reply: assert property (
    wr_err |=> s_reply_start(error_reply, LEN_ERROR))
    else $error("bad write gave no error reply");
  a_foreign_drop: assert property (
    frame_end && !addr_ok |=> state_reg == st_idle && !tx_valid_reg)
    else $error("foreign frame not dropped");
  a_wild_match: assert property (
    go && rd && rd_known && addr_reg == WILDCARD |=> state_reg == st_send)
    else $error("wildcard read not answered");
endmodule : ascii_command_parser

// >>> rtl/parser_pkg.sv
package parser_pkg;
  // ----------------------------------------------------------------
  // Character codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_START = 8'h23;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_EQ = 8'h3D;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [15:0] CASE_BITS = 16'h2020;
  localparam logic [15:0] WILDCARD = 16'h2A2A;
  localparam logic [15:0] STATION_RESET = 16'h3031;
  localparam logic [15:0] STATION_NONE = 16'h3030;
  // ----------------------------------------------------------------
  // Command letter pairs, upper case form
  // ----------------------------------------------------------------
  localparam logic [15:0] LETTERS_STATION = 16'h4144;
  localparam logic [15:0] LETTERS_LINE_SPEED = 16'h4252;
  localparam logic [15:0] LETTERS_NVM_DUMP = 16'h4544;
  localparam logic [15:0] LETTERS_NVM_PEEK = 16'h4552;
  localparam logic [15:0] LETTERS_NVM_POKE = 16'h4557;
  localparam logic [15:0] LETTERS_RANGE = 16'h4653;
  localparam logic [15:0] LETTERS_VERSION = 16'h4656;
  localparam logic [15:0] LETTERS_TAG = 16'h484C;
  localparam logic [15:0] LETTERS_PRESSURE = 16'h5053;
  localparam logic [15:0] LETTERS_KIND = 16'h5054;
  localparam logic [15:0] LETTERS_RAW = 16'h5243;
  // ----------------------------------------------------------------
  // Reply lengths, CR LF included
  // ----------------------------------------------------------------
  localparam logic [6:0] LEN_STATION = 7'd7;
  localparam logic [6:0] LEN_SPEED = 7'd11;
  localparam logic [6:0] LEN_DUMP_LINE = 7'd65;
  localparam logic [6:0] LEN_NVM = 7'd5;
  localparam logic [6:0] LEN_RANGE = 7'd13;
  localparam logic [6:0] LEN_VERSION = 7'd7;
  localparam logic [6:0] LEN_TAG = 7'd11;
  localparam logic [6:0] LEN_PRESSURE = 7'd13;
  localparam logic [6:0] LEN_KIND = 7'd6;
  localparam logic [6:0] LEN_RAW = 7'd54;
  localparam logic [6:0] LEN_ERROR = 7'd7;
  localparam logic [6:0] DUMP_CR_POS = 7'd63;
  localparam logic [3:0] DUMP_LAST_LINE = 4'd9;
  localparam int MSG_CHARS = 54;
  localparam int NVM_DEPTH = 256;
  localparam logic [2:0] VALUE_CHARS = 3'd6;
  localparam logic [9:0] BYTE_MAX = 10'd255;
  // ----------------------------------------------------------------
  // Line speeds, left justified, space padded
  // ----------------------------------------------------------------
  localparam int RATE_COUNT = 8;
  localparam logic [2:0] RATE_RESET = 3'd3;
  localparam logic [0:7][47:0] RATE_TEXT = {"1200  ", "2400  ",
    "4800  ", "9600  ", "19200 ", "38400 ", "57600 ", "115200"};
  // Version text is arbitrary, not any real firmware level
  localparam logic [39:0] VERSION_TEXT = "X1.00";
  localparam logic [39:0] ERROR_TEXT = "Err03";
  typedef enum {st_idle, st_addr_hi, st_addr_lo, st_cmd_hi, st_cmd_lo,
    st_value, st_send} state_t;
  typedef enum {station_cmd, line_speed_cmd, nvm_dump_cmd, nvm_peek_cmd,
    nvm_poke_cmd, range_limit_cmd, code_version_cmd, serial_tag_cmd,
    pressure_query_cmd, sensing_kind_cmd, raw_sample_cmd,
    error_reply} reply_t;
endpackage : parser_pkg

// >>> tb/host_model.sv
module host_model (
  input wire logic clk,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Host side of the serial link
  // ----------------------------------------------------------------
  logic [7:0] got[$];
  bit slow;
  // Idle host offers nothing; the released line shows the inverse
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
    slow = 1'b0;
  end
  // One frame: start mark, address, letters, value, CR
  task automatic send(input string s);
    #1;
    for (int i = 0; i < s.len(); i++) begin
      rx_data = s[i];
      rx_valid = 1'b1;
      do @(posedge clk); while (rx_ready !== 1'b1);
      #1;
    end
    rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask : send
  // Sink stalls every other cycle in slow mode
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      got.push_back(tx_data);
    end
    #1 tx_ready <= slow ? ~tx_ready : 1'b1;
  end
endmodule : host_model

// >>> tb/ascii_transducer_command_parser_tb.sv
module ascii_transducer_command_parser_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Bench signals
  // ----------------------------------------------------------------
  localparam string RAW_S =
    "R0123456789ABCDEFGHIJKLMNOPQRSTUVWXYZabcdefghijklmno";
  string rates[8] = '{"1200", "2400", "4800", "9600", "19200",
    "38400", "57600", "115200"};
  logic clk, reset_n, rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0] rx_data, tx_data, kind_char;
  logic [63:0] pressure_text, range_text;
  logic [47:0] serial_text;
  logic [415:0] raw_text;
  logic [2:0] line_speed_sel;
  logic coeff_reload;
  int n_errors, check_count, cycles, n_reload;
  ascii_command_parser i_ascii_command_parser (.clk(clk),
    .reset_n(reset_n), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .pressure_text(pressure_text),
    .range_text(range_text), .serial_text(serial_text),
    .kind_char(kind_char), .raw_text(raw_text),
    .line_speed_sel(line_speed_sel), .coeff_reload(coeff_reload));
  host_model i_host_model (.clk(clk), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .rx_data(rx_data),
    .rx_valid(rx_valid), .tx_ready(tx_ready));
  // Free running clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Cut a hang short well past the longest expected run
  always @(posedge clk) begin
    cycles++;
    if (coeff_reload === 1'b1) n_reload++;
    if (cycles == 60000) begin
      n_errors++;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  // Send a frame and compare the whole reply, or silence
  task automatic xfer(input string f, input string e);
    int w;
    i_host_model.got.delete();
    i_host_model.send({f, "\r"});
    w = 0;
    while (i_host_model.got.size() < e.len() && w < 3000) begin
      @(posedge clk);
      w++;
    end
    repeat (40) @(posedge clk);
    check_count++;
    if (i_host_model.got.size() != e.len()) begin
      n_errors++;
      $display("CHECK FAILED %s length exp %0d seen %0d", f, e.len(),
        i_host_model.got.size());
    end else for (int i = 0; i < e.len(); i++) begin
      if (i_host_model.got[i] !== e[i]) begin
        n_errors++;
        $display("CHECK FAILED %s char %0d exp %h seen %h", f, i, e[i],
          i_host_model.got[i]);
        break;
      end
    end
  endtask : xfer
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_station;
    xfer("#01AD", "AD=01\r\n");
    xfer("#**AD", "AD=01\r\n");
    xfer("#01ad99", "");
    xfer("#99AD", "AD=99\r\n");
    xfer("#01AD", "");
    xfer("#99ad00", "Err03\r\n");
    xfer("#99ad01", "");
  endtask : t_station
  task automatic t_speed;
    string r;
    for (int i = 0; i < 8; i++) begin
      xfer({"#01br", rates[i]}, "");
      check_count++;
      if (line_speed_sel !== 3'(i)) begin
        n_errors++;
        $display("CHECK FAILED speed exp %0d seen %h", i, line_speed_sel);
      end
      r = rates[i];
      while (r.len() < 6) r = {r, " "};
      xfer("#01BR", {"BR=", r, "\r\n"});
    end
    xfer("#01br300", "Err03\r\n");
    xfer("#01br9600", "");
  endtask : t_speed
  // Peek sets the pointer, poke stores and echoes under a stalling sink
  task automatic t_nvm;
    int n0;
    i_host_model.slow = 1'b1;
    xfer("#01ER005", "000\r\n");
    n0 = n_reload;
    xfer("#01ew255", "255\r\n");
    check_count++;
    if (n_reload != n0 + 1) begin
      n_errors++;
      $display("CHECK FAILED reload exp %0d seen %0d", n0 + 1, n_reload);
    end
    xfer("#01ER005", "255\r\n");
    xfer("#01ER256", "");
    xfer("#01ew256", "Err03\r\n");
    i_host_model.slow = 1'b0;
  endtask : t_nvm
  task automatic t_dump;
    string e;
    e = "";
    for (int i = 0; i < 160; i++) begin
      // Only location 5 was poked earlier; the rest stay cleared
      if (i == 5) e = {e, "255"};
      else e = {e, "000"};
      if (i % 16 == 15) e = {e, "\r\n"};
      else e = {e, " "};
    end
    xfer("#01ED", e);
  endtask : t_dump
  task automatic t_reads;
    string k;
    k = "ACGV";
    xfer("#01FS", "FS=+100.000\r\n");
    xfer("#01FV", "X1.00\r\n");
    xfer("#01HL", "HL=004711\r\n");
    xfer("#01PS", "PS=-012.345\r\n");
    xfer("#01RC", {RAW_S, "\r\n"});
    for (int i = 0; i < 4; i++) begin
      kind_char <= k[i];
      xfer("#01PT", {"PT=", k.substr(i, i), "\r\n"});
    end
  endtask : t_reads
  // Malformed frames: silence for reads, error for writes, a reply to the read after a start mark resync
  task automatic t_faults;
    xfer("#01PS1", "");
    xfer("#01ZZ", "");
    xfer("#01Ps", "");
    xfer("#01zz5", "Err03\r\n");
    xfer("#0#01PT", "PT=V\r\n");
    xfer("#01ulUNIT 100", "Err03\r\n");
  endtask : t_faults
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    pressure_text = "-012.345";
    range_text = "+100.000";
    serial_text = "004711";
    kind_char = "G";
    for (int i = 0; i < 52; i++) raw_text[(51 - i) * 8 +: 8] = RAW_S[i];
    repeat (10) @(posedge clk);
    #1 reset_n = 1'b1;
    t_station();
    t_speed();
    t_nvm();
    t_dump();
    t_reads();
    t_faults();
    close_out();
  end
endmodule : ascii_transducer_command_parser_tb
